// [rtl/mbes_cfg.svh]
`ifndef MBES_CFG_SVH
`define MBES_CFG_SVH
// register word offsets
`define MBES_OFF_CTRL      4'h0
`define MBES_OFF_STATUS    4'h1
`define MBES_OFF_MENU      4'h2
`define MBES_OFF_ERROR     4'h3
`define MBES_OFF_EVT       4'h4
`define MBES_OFF_EVT_CLR   4'h5
`define MBES_OFF_EVT_EN    4'h6
`define MBES_OFF_FAULT_SET 4'h7
// ctrl fields
`define MBES_CTRL_BAUD_LSB 0
`define MBES_CTRL_RST      32'h0000_0000
// fault codes
`define MBES_CODE_EMERG    16'h0064
`define MBES_CODE_BATT     16'h03E8
`define MBES_CODE_HW       16'h1F41
// timing
`define MBES_TICK_NS       1000000
`define MBES_CLK_NS        4
`define MBES_TICK_CYC      (`MBES_TICK_NS / `MBES_CLK_NS)
`define MBES_DEB_TICKS     5
`define MBES_LONG_MS       2000
`define MBES_LONG_TICKS    (`MBES_LONG_MS)
`define MBES_HOLD_TICKS    4000
// menu sizes per level
`define MBES_L1_ITEMS      4
`define MBES_L2_ITEMS      4
`define MBES_L3_ITEMS      3
`define MBES_BATT_ITEM     2
`endif

// [rtl/mbes_debounce.sv]
`include "mbes_cfg.svh"
module mbes_debounce #(
  parameter int DEB_TICKS = `MBES_DEB_TICKS
) (
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_i,      // sync reset
  input  wire logic ce_i,       // clock enable
  input  wire logic tick_i,     // slow tick
  input  wire logic btn_raw_i,  // raw pin, async
  output logic      btn_o       // debounced level
);
  initial begin
    if (DEB_TICKS < 1 || DEB_TICKS > 255) $error("bad DEB_TICKS");
  end
  logic       sync1;
  logic       sync2;
  logic [7:0] cnt;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else if (ce_i) begin
      sync1 <= btn_raw_i;
      sync2 <= sync1;
    end
  end
  // level must be stable for DEB_TICKS ticks before it is accepted
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt   <= 8'h00;
      btn_o <= 1'b0;
    end else if (ce_i) begin
      if (sync2 == btn_o) begin
        cnt <= 8'h00;
      end else if (tick_i) begin
        if (cnt == 8'(DEB_TICKS - 1)) begin
          btn_o <= sync2;
          cnt   <= 8'h00;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule : mbes_debounce

// [rtl/mbes_pkg.sv]
package mbes_pkg;
  typedef enum logic [1:0] {
    MBES_BAUD_2400 = 2'b00,
    MBES_BAUD_300  = 2'b01,
    MBES_BAUD_9600 = 2'b10
  } mbes_baud_t;
  typedef enum logic [1:0] {
    MBES_IDLE = 2'b00,
    MBES_DOWN = 2'b01,
    MBES_LONG = 2'b11,
    MBES_HOLD = 2'b10
  } mbes_press_t;
endpackage : mbes_pkg

// [rtl/mbes_press.sv]
`include "mbes_cfg.svh"
module mbes_press
  import mbes_pkg::*;
#(
  parameter int LONG_TICKS = `MBES_LONG_TICKS,
  parameter int HOLD_TICKS = `MBES_HOLD_TICKS
) (
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_i,      // sync reset
  input  wire logic ce_i,       // clock enable
  input  wire logic tick_i,     // slow tick
  input  wire logic btn_i,      // debounced button
  output logic      short_o,    // short press pulse
  output logic      long_o,     // long release pulse
  output logic      hold_o,     // hold reached pulse
  output logic      door_o      // long press recognised
);
  initial begin
    if (HOLD_TICKS <= LONG_TICKS || HOLD_TICKS > 65535 || LONG_TICKS < 1)
      $error("hold must exceed long");
  end
  mbes_press_t st;
  logic [15:0] cnt;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st      <= MBES_IDLE;
      cnt     <= 16'h0000;
      short_o <= 1'b0;
      long_o  <= 1'b0;
      hold_o  <= 1'b0;
    end else if (ce_i) begin
      short_o <= 1'b0;
      long_o  <= 1'b0;
      hold_o  <= 1'b0;
      unique case (st)
        MBES_IDLE: begin
          cnt <= 16'h0000;
          if (btn_i) st <= MBES_DOWN;
        end
        MBES_DOWN: begin
          if (!btn_i) begin
            short_o <= 1'b1;
            st      <= MBES_IDLE;
          end else if (tick_i) begin
            cnt <= cnt + 16'h0001;
            if (cnt == 16'(LONG_TICKS - 1)) st <= MBES_LONG;
          end
        end
        MBES_LONG: begin
          if (!btn_i) begin
            long_o <= 1'b1;
            st     <= MBES_IDLE;
          end else if (tick_i) begin
            cnt <= cnt + 16'h0001;
            if (cnt == 16'(HOLD_TICKS - 1)) begin
              hold_o <= 1'b1;
              st     <= MBES_HOLD;
            end
          end
        end
        MBES_HOLD: begin
          if (!btn_i) st <= MBES_IDLE;
        end
      endcase
    end
  end
  assign door_o = (st == MBES_LONG);
endmodule : mbes_press

// [rtl/mbes_top.sv]
// Our own choices: register access over Avalon-MM and the register addresses.
`include "mbes_cfg.svh"
module mbes_top
  import mbes_pkg::*;
#(
  parameter int TICK_CYC   = `MBES_TICK_CYC,
  parameter int DEB_TICKS  = `MBES_DEB_TICKS,
  parameter int LONG_TICKS = `MBES_LONG_TICKS,
  parameter int HOLD_TICKS = `MBES_HOLD_TICKS
) (
  input  wire logic        sys_clk_i,        // 250 MHz clock
  input  wire logic        rst_i,            // sync reset, high
  input  wire logic        ce_i,             // clock enable
  input  wire logic        btn_raw_i,        // push button pin
  input  wire logic        ext_pwr_i,        // external supply good, pin
  input  wire logic        emerg_i,          // emergency condition, pin
  input  wire logic        batt_exp_i,       // battery life expired, pin
  input  wire logic        hw_fault_i,       // hardware fault, pin
  input  wire logic        meas_i,           // measuring cycle pulse, same clock
  input  wire logic        flow_i,           // flow present, same clock
  input  wire logic        tx_act_i,         // data transmission, same clock
  input  wire logic [3:0]  avs_address,      // word address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  output logic [31:0]      avs_readdata,     // read data
  output logic             avs_waitrequest,  // wait
  output logic [1:0]       menu_level_o,     // shown level 0..2
  output logic [1:0]       menu_item_o,      // shown item
  output logic             submenu_o,        // in submenu
  output logic             refresh_o,        // refresh pulse
  output logic             door_o,           // door symbol
  output logic [15:0]      err_code_o,       // displayed error sum
  output logic [3:0]       sym_o,            // flow,tx,emerg,ext symbols
  output logic             ext_line_o,       // vertical line symbol
  output logic             on_batt_o,        // running from battery
  output logic             batt_date_o,      // battery date item shown
  output logic [1:0]       baud_sel_o,       // serial baud select
  output logic             irq_o             // interrupt level
);
  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 1000000) $error("bad TICK_CYC");
  end

  // slow tick for debounce and press timing
  logic [19:0] tick_cnt;
  logic        tick;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_cnt <= 20'h0_0000;
      tick     <= 1'b0;
    end else if (ce_i) begin
      tick <= 1'b0;
      if (tick_cnt == 20'(TICK_CYC - 1)) begin
        tick_cnt <= 20'h0_0000;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 20'h0_0001;
      end
    end
  end

  logic btn;
  logic p_short;
  logic p_long;
  logic p_hold;
  logic p_door;
  mbes_debounce #(.DEB_TICKS(DEB_TICKS)) u_deb (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_i    (tick),
    .btn_raw_i (btn_raw_i),
    .btn_o     (btn)
  );
  mbes_press #(.LONG_TICKS(LONG_TICKS), .HOLD_TICKS(HOLD_TICKS)) u_press (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_i    (tick),
    .btn_i     (btn),
    .short_o   (p_short),
    .long_o    (p_long),
    .hold_o    (p_hold),
    .door_o    (p_door)
  );

  // pin synchronisers: s1 feeds only s2
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else if (ce_i) begin
      pin_s1 <= {hw_fault_i, batt_exp_i, emerg_i, ext_pwr_i};
      pin_s2 <= pin_s1;
    end
  end
  logic ext_pwr;
  logic emerg;
  logic batt_exp;
  logic hw_fault;
  assign ext_pwr  = pin_s2[0];
  assign emerg    = pin_s2[1];
  assign batt_exp = pin_s2[2];
  assign hw_fault = pin_s2[3];

  // menu navigation
  logic [1:0] lvl_items;
  always_comb begin
    unique case (menu_level_o)
      2'd0:    lvl_items = 2'(`MBES_L1_ITEMS - 1);
      2'd1:    lvl_items = 2'(`MBES_L2_ITEMS - 1);
      default: lvl_items = 2'(`MBES_L3_ITEMS - 1);
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      menu_level_o <= 2'd0;
      menu_item_o  <= 2'd0;
      submenu_o    <= 1'b0;
      refresh_o    <= 1'b0;
    end else if (ce_i) begin
      refresh_o <= 1'b0;
      if (p_short) begin
        if (menu_item_o == lvl_items) menu_item_o <= 2'd0;
        else menu_item_o <= menu_item_o + 2'd1;
      end else if (p_long) begin
        if (menu_item_o == 2'd0 && !submenu_o) refresh_o <= 1'b1;
        else submenu_o <= 1'b1;
      end else if (p_hold) begin
        menu_item_o <= 2'd0;
        if (submenu_o) begin
          submenu_o <= 1'b0;
        end else if (menu_level_o == 2'd2) begin
          menu_level_o <= 2'd0;
        end else begin
          menu_level_o <= menu_level_o + 2'd1;
        end
      end
    end
  end

  // latched faults: a press clears, the set of the same cycle wins
  logic [2:0] fault;
  logic [2:0] fault_sw;
  logic       press_any;
  assign press_any = p_short | p_long | p_hold;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fault <= 3'b000;
    end else if (ce_i) begin
      fault <= ((press_any ? 3'b000 : fault)
               | ({3{meas_i}} & {hw_fault, batt_exp, emerg})
               | fault_sw);
    end
  end
  logic [15:0] next_err;
  always_comb begin
    next_err = 16'h0000;
    if (fault[0]) next_err = next_err + `MBES_CODE_EMERG;
    if (fault[1]) next_err = next_err + `MBES_CODE_BATT;
    if (fault[2]) next_err = next_err + `MBES_CODE_HW;
  end

  logic main_item;
  assign main_item = (menu_level_o == 2'd0) && (menu_item_o == 2'd0) && !submenu_o;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err_code_o  <= 16'h0000;
      sym_o       <= 4'h0;
      ext_line_o  <= 1'b0;
      on_batt_o   <= 1'b1;
      door_o      <= 1'b0;
      batt_date_o <= 1'b0;
    end else if (ce_i) begin
      err_code_o  <= next_err;
      sym_o       <= main_item ? {ext_pwr, emerg, tx_act_i, flow_i} : 4'h0;
      ext_line_o  <= ext_pwr;
      on_batt_o   <= !ext_pwr;
      door_o      <= p_door;
      batt_date_o <= (menu_level_o == 2'd2)
                     && (menu_item_o == 2'(`MBES_BATT_ITEM));
    end
  end

  // registers and events
  logic [2:0] evt;
  logic [2:0] evt_en;
  logic [2:0] evt_clr;
  logic [2:0] evt_new;
  logic       wr_ok;
  assign wr_ok   = avs_write && !avs_waitrequest;
  assign evt_new = {ext_pwr == on_batt_o, p_long, p_short};
  always_comb begin
    evt_clr  = 3'b000;
    fault_sw = 3'b000;
    if (wr_ok && avs_address == `MBES_OFF_EVT_CLR) evt_clr = avs_writedata[2:0];
    if (wr_ok && avs_address == `MBES_OFF_FAULT_SET) fault_sw = avs_writedata[2:0];
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      evt    <= 3'b000;
      evt_en <= 3'b000;
      baud_sel_o <= 2'b00;
      irq_o  <= 1'b0;
    end else if (ce_i) begin
      evt   <= (evt & ~evt_clr) | evt_new;
      irq_o <= |(evt & evt_en);
      if (wr_ok && avs_address == `MBES_OFF_EVT_EN) evt_en <= avs_writedata[2:0];
      if (wr_ok && avs_address == `MBES_OFF_CTRL && avs_writedata[1:0] != 2'b11)
        baud_sel_o <= avs_writedata[1:0];
    end
  end

  // one wait cycle per access, data registered
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce_i) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        unique case (avs_address)
          `MBES_OFF_CTRL:   avs_readdata <= {30'h0, baud_sel_o};
          `MBES_OFF_STATUS: avs_readdata <= {28'h0, fault, on_batt_o};
          `MBES_OFF_MENU:   avs_readdata <= {27'h0, submenu_o, menu_level_o, menu_item_o};
          `MBES_OFF_ERROR:  avs_readdata <= {16'h0, err_code_o};
          `MBES_OFF_EVT:    avs_readdata <= {29'h0, evt};
          `MBES_OFF_EVT_EN: avs_readdata <= {29'h0, evt_en};
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_wrap_item: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_short && menu_item_o == lvl_items |=> menu_item_o == 2'd0)
    else $error("menu did not wrap");
  a_step_item: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_short && menu_item_o != lvl_items |=> menu_item_o == $past(menu_item_o) + 2'd1)
    else $error("menu did not step");
  a_sym_main: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !main_item |=> sym_o == 4'h0)
    else $error("symbols off main item");
  a_ext_line: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> ext_line_o == !on_batt_o)
    else $error("supply line mismatch");
  a_batt_fallback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !ext_pwr |=> on_batt_o)
    else $error("no battery fallback");
  a_err_sum: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && fault == 3'b011 |=> err_code_o == 16'h044C)
    else $error("error sum wrong");
  a_press_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_short && !meas_i && fault_sw == 3'b000 |=> fault == 3'b000)
    else $error("press did not clear");
  a_door_long: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_long |-> door_o)
    else $error("long release without door");
  a_hold_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_hold && !submenu_o && menu_level_o == 2'd0 |=> menu_level_o == 2'd1)
    else $error("hold did not change level");
  a_baud_legal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    baud_sel_o != 2'b11)
    else $error("illegal baud");

  // steps shared by the menu checks below
  sequence s_long_main;
    ce_i && p_long && menu_item_o == 2'd0 && !submenu_o;
  endsequence
  sequence s_hold_sub;
    ce_i && p_hold && submenu_o;
  endsequence
  sequence s_hold_top;
    ce_i && p_hold && !submenu_o && menu_level_o == 2'd2;
  endsequence
  // a long release on item 0 outside a submenu refreshes on any level, not only the first
  a_long_refresh: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_long_main |=> refresh_o)
    else $error("long release did not refresh");
  a_long_enter: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_long && (menu_item_o != 2'd0 || submenu_o) |=> submenu_o)
    else $error("long release did not enter submenu");
  a_refresh_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && refresh_o |=> !refresh_o)
    else $error("refresh longer than one cycle");
  a_hold_leave: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_hold_sub |=> !submenu_o && menu_item_o == 2'd0)
    else $error("hold did not leave submenu");
  a_hold_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_hold_top |=> menu_level_o == 2'd0)
    else $error("hold did not wrap level");
  a_level_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    menu_level_o != 2'd3)
    else $error("level out of range");
  a_item_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    menu_item_o <= lvl_items)
    else $error("item beyond last");
  a_short_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_short |=> menu_level_o == $past(menu_level_o))
    else $error("short press changed level");
  a_door_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && p_door |=> door_o)
    else $error("door symbol missing");
  a_door_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !p_door |=> !door_o)
    else $error("door symbol stuck");
  a_err_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && fault == 3'b111 |=> err_code_o == 16'h238D)
    else $error("full error sum wrong");
  a_emerg_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && fault == 3'b001 |=> err_code_o == 16'h0064)
    else $error("emergency code wrong");
  a_hw_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && fault == 3'b100 |=> err_code_o > 16'h1F40)
    else $error("hardware code too low");
  a_fault_relatch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && meas_i && emerg |=> fault[0])
    else $error("persisting fault not latched");
  a_batt_item: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && menu_level_o == 2'd2 && menu_item_o == 2'd2 |=> batt_date_o)
    else $error("battery date item not shown");
  a_press_onehot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i |-> $onehot0({p_short, p_long, p_hold}))
    else $error("press classes overlap");
  a_supply_evt: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && ext_pwr == on_batt_o |=> evt[2])
    else $error("supply change not flagged");
  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && |(evt & evt_en) |=> irq_o)
    else $error("interrupt not raised");
endmodule : mbes_top

// [testbench/mbes_btn_model.sv]
// push button as the operator works it: pressed drives high, idle low
module mbes_btn_model (
  input  wire logic sys_clk_i,  // bench clock
  output logic      btn_o       // contact level, pressed high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial btn_o = 1'b0;
  // chatter lasts six cycles, shorter than one debounce window
  task automatic settle(input logic lvl, input bit bounce);
    int i;
    if (bounce) begin
      for (i = 0; i < 3; i++) begin
        @(posedge sys_clk_i);
        btn_o <= lvl;
        @(posedge sys_clk_i);
        btn_o <= !lvl;
      end
    end
    @(posedge sys_clk_i);
    btn_o <= lvl;
  endtask : settle
endmodule : mbes_btn_model

// [testbench/mbes_top_tb.sv]
`include "mbes_cfg.svh"
module mbes_top_tb
  import mbes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i, rst_i, ce_i, btn_raw, ext_pwr, emerg, batt_exp, hw_fault;
  logic        meas, flow, tx_act, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, sym;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0]  lvl, item, baud;
  logic        sub, refresh, door, ext_line, on_batt, batt_date, irq;
  logic [15:0] err_code;
  int          n_fail, num_checks, i;

  mbes_top #(.TICK_CYC(4), .DEB_TICKS(2), .LONG_TICKS(5), .HOLD_TICKS(10)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .btn_raw_i(btn_raw),
    .ext_pwr_i(ext_pwr), .emerg_i(emerg), .batt_exp_i(batt_exp), .hw_fault_i(hw_fault),
    .meas_i(meas), .flow_i(flow), .tx_act_i(tx_act), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .menu_level_o(lvl), .menu_item_o(item), .submenu_o(sub), .refresh_o(refresh),
    .door_o(door), .err_code_o(err_code), .sym_o(sym), .ext_line_o(ext_line),
    .on_batt_o(on_batt), .batt_date_o(batt_date), .baud_sel_o(baud), .irq_o(irq));

  mbes_btn_model i_btn (.sys_clk_i(sys_clk_i), .btn_o(btn_raw));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // selector: 0 item 1 level 2 sub 3 door 4 error 5 refresh 6 irq 7 sym 8 date 9 line
  function automatic logic [31:0] cur(input int sel);
    case (sel)
      0: cur = 32'(item);
      1: cur = 32'(lvl);
      2: cur = 32'(sub);
      3: cur = 32'(door);
      4: cur = 32'(err_code);
      5: cur = 32'(refresh);
      6: cur = 32'(irq);
      7: cur = 32'(sym);
      8: cur = 32'(batt_date);
      9: cur = 32'(ext_line);
      10: cur = 32'(on_batt);
      default: cur = 32'(baud);
    endcase
  endfunction : cur

  task automatic await(input int sel, input logic [31:0] exp);
    int k;
    for (k = 0; k < 200 && cur(sel) !== exp; k++) @(posedge sys_clk_i);
  endtask : await

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // short press: chatter on contact, three ticks held, well below the long count
  task automatic tap();
    i_btn.settle(1'b1, 1'b1);
    repeat (12) @(posedge sys_clk_i);
    i_btn.settle(1'b0, 1'b0);
  endtask : tap

  // held until the menu reacts, then let go
  task automatic hold_until(input int sel, input logic [31:0] exp);
    i_btn.settle(1'b1, 1'b0);
    await(sel, exp);
    i_btn.settle(1'b0, 1'b0);
    await(3, 32'h0000_0000);
    repeat (16) @(posedge sys_clk_i); // debounced release must land before the next press
  endtask : hold_until

  task automatic measure();
    repeat (4) @(posedge sys_clk_i);
    meas <= 1'b1;
    @(posedge sys_clk_i);
    meas <= 1'b0;
  endtask : measure

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    {rst_i, ce_i, ext_pwr} = 3'b111;
    {emerg, batt_exp, hw_fault, meas, flow, tx_act, avs_read, avs_write} = 8'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    repeat (5) @(posedge sys_clk_i);
    check(cur(11), 32'h0000_0000);
    check(cur(10), 32'h0000_0001);
    rst_i <= 1'b0;
    bus_rd(`MBES_OFF_CTRL, rd);
    check(rd, 32'h0000_0000);
    for (i = 1; i < 4; i++) begin
      bus_wr(`MBES_OFF_CTRL, 32'(i));
      bus_rd(`MBES_OFF_CTRL, rd);
      check(rd, (i == 3) ? 32'h0000_0002 : 32'(i));
      check(cur(11), (i == 3) ? 32'h0000_0002 : 32'(i));
    end
    bus_wr(`MBES_OFF_CTRL, 32'h0000_0000);
    bus_rd(4'hF, rd);
    check(rd, 32'h0000_0000);
    await(9, 32'h0000_0001);
    check(cur(9), 32'h0000_0001);
    check(cur(10), 32'h0000_0000);
    flow   <= 1'b1;
    tx_act <= 1'b1;
    await(7, 32'h0000_000B);
    check(cur(7), 32'h0000_000B);
    bus_wr(`MBES_OFF_EVT_CLR, 32'h0000_0007);
    bus_wr(`MBES_OFF_EVT_EN, 32'h0000_0001);
    check(cur(6), 32'h0000_0000);
    for (i = 1; i < 5; i++) begin
      tap();
      await(0, 32'(i % 4));
      check(cur(0), 32'(i % 4));
      @(posedge sys_clk_i);
      check(cur(7), (i == 4) ? 32'h0000_000B : 32'h0000_0000);
    end
    await(6, 32'h0000_0001);
    check(cur(6), 32'h0000_0001);
    bus_wr(`MBES_OFF_EVT_CLR, 32'h0000_0001);
    bus_wr(`MBES_OFF_EVT_EN, 32'h0000_0000);
    check(cur(6), 32'h0000_0000);
    tap();
    await(0, 32'h0000_0001);
    bus_rd(`MBES_OFF_EVT, rd);
    check(rd & 32'h0000_0001, 32'h0000_0001);
    check(cur(6), 32'h0000_0000);
    bus_wr(`MBES_OFF_EVT_EN, 32'h0000_0001);
    await(6, 32'h0000_0001);
    check(cur(6), 32'h0000_0001);
    i_btn.settle(1'b1, 1'b0);
    await(3, 32'h0000_0001);
    check(cur(3), 32'h0000_0001);
    i_btn.settle(1'b0, 1'b0);
    await(2, 32'h0000_0001);
    check(cur(2), 32'h0000_0001);
    hold_until(2, 32'h0000_0000);
    check(cur(2) | cur(1) | cur(0), 32'h0000_0000);
    i_btn.settle(1'b1, 1'b0);
    await(3, 32'h0000_0001);
    i_btn.settle(1'b0, 1'b0);
    await(5, 32'h0000_0001);
    check(cur(5), 32'h0000_0001);
    check(cur(2), 32'h0000_0000);
    hold_until(1, 32'h0000_0001);
    check(cur(1), 32'h0000_0001);
    check(cur(7), 32'h0000_0000);
    hold_until(1, 32'h0000_0002);
    check(cur(1), 32'h0000_0002);
    tap();
    await(0, 32'h0000_0001);
    tap();
    await(8, 32'h0000_0001);
    check(cur(8), 32'h0000_0001);
    bus_rd(`MBES_OFF_MENU, rd);
    check(rd, 32'h0000_000A);
    tap();
    await(0, 32'h0000_0000);
    @(posedge sys_clk_i);
    check(cur(0) | cur(8), 32'h0000_0000);
    hold_until(1, 32'h0000_0000);
    check(cur(1), 32'h0000_0000);
    emerg    <= 1'b1;
    batt_exp <= 1'b1;
    measure();
    await(4, 32'd1100);
    check(cur(4), 32'd1100);
    hw_fault <= 1'b1;
    measure();
    await(4, 32'd1100 + 32'(`MBES_CODE_HW));
    bus_rd(`MBES_OFF_ERROR, rd);
    check(rd, 32'd1100 + 32'(`MBES_CODE_HW));
    check(32'(`MBES_CODE_HW > 16'd8000), 32'h0000_0001);
    bus_rd(`MBES_OFF_STATUS, rd);
    check(rd, 32'h0000_000E);
    batt_exp <= 1'b0;
    hw_fault <= 1'b0;
    tap();
    await(4, 32'h0000_0000);
    check(cur(4), 32'h0000_0000);
    measure();
    await(4, 32'd100);
    check(cur(4), 32'd100);
    ext_pwr <= 1'b0;
    await(10, 32'h0000_0001);
    check(cur(10), 32'h0000_0001);
    check(cur(9), 32'h0000_0000);
    bus_rd(`MBES_OFF_EVT, rd);
    check(rd & 32'h0000_0004, 32'h0000_0004);
    tally_and_finish();
  end
endmodule : mbes_top_tb
